// >>> verilog/scr_defs.vh
/*
 Register offsets, field positions, reset values and event bit layout
 for the secondary command block. Assumes inclusion by bare name.
*/
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH
`define SCR_ADDR_W 8
`define SCR_OFF_CMD 8'h44
`define SCR_OFF_IRQ_STAT 8'h80
`define SCR_OFF_IRQ_MASK 8'h84
`define SCR_OFF_CTRL 8'h88
`define SCR_BIT_IO_EN 0
`define SCR_BIT_MEM_EN 1
`define SCR_BIT_BM_EN 2
`define SCR_BIT_PERR_EN 6
`define SCR_BIT_SERR_EN 8
`define SCR_BIT_INTX_DIS 10
`define SCR_BIT_MDPE 24
`define SCR_CMD_RW_MASK 16'h0147
`define SCR_CMD_RESET 16'h0000
`define SCR_EV_MDPE 0
`define SCR_EV_SERR 1
`define SCR_EV_BLOCKED 2
`define SCR_EV_W 3
`define SCR_EV_RESET 3'h0
`define SCR_CTRL_RESET 1'h0
`endif

// >>> verilog/scr_sync.v
/*
 Two flip-flop level synchroniser, width set by a parameter.
 Assumes the input comes from another clock domain or a pin.
*/
module scr_sync #(
	parameter W = 1
) (
	// Clock and reset.
	input wire clk_sys,
	input wire resetn,
	// Data.
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);
	reg [W-1:0] meta_q;

	always @(posedge clk_sys) begin
		if (!resetn) begin
			meta_q <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// >>> verilog/scr_cmd_reg.v
/*
 Secondary command register of a reversible bridge with the master data
 parity error status bit, event interrupt status and mask, and the gates
 that the command bits put on the secondary datapath. Assumes the datapath
 logic runs on clk_sys and that the direction strap is a pin.
*/
// What this block does
// - I/O enable clear makes the secondary side ignore I/O transactions.
// - Memory enable clear makes the secondary side ignore memory reads.
// - Master enable clear blocks initiating and answering memory and I/O.
// - Master enable set allows mastering forwarded memory and I/O cycles.
// - Reverse bridge with PCI-X secondary may always start split completions.
// - Special cycle enable bit 3 reads zero and is read-only.
// - Memory write and invalidate enable bit 4 reads zero, read-only.
// - Palette snoop bit 5 reads zero; palette snoops are ignored.
// - Parity response enable set lets parity errors set bit 24.
// - Parity response enable clear lets parity errors be ignored.
// - Wait cycle control bit 7 reads zero and is read-only.
// - Forward mode: error enable gates error messages to the root.
// - Reverse mode: error enable gates the secondary system error pin.
// - Fast back-to-back bit 9 reads zero and is read-only.
// - Interrupt disable clear permits INTx messages.
// - Interrupt disable set blocks new INTx and releases asserted ones.
// - Bit 24 is write-one-to-clear and resets to zero.
// The header comes first because the port list uses its address width.
`include "scr_defs.vh"
module scr_cmd_reg #(
	parameter INTX_DIS_RW_FWD = 1,
	parameter INTX_DIS_RW_REV = 0
) (
	// Clock and reset.
	input wire clk_sys,
	input wire resetn,
	// Register port.
	input wire [`SCR_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Bridge straps, pins from outside the clock domain.
	input wire reverse_mode_pin,
	input wire pcix_mode_pin,
	// Secondary side requests from the datapath.
	input wire io_req,
	input wire mem_rd_req,
	input wire mem_req,
	input wire master_req,
	input wire split_cpl_req,
	input wire special_cycle_req,
	input wire palette_snoop_req,
	input wire parity_err,
	input wire fatal_err,
	input wire intx_req,
	// Gates back to the datapath.
	output wire io_accept,
	output wire mem_rd_accept,
	output wire mem_accept,
	output wire master_grant,
	output wire split_cpl_grant,
	output wire special_cycle_accept,
	output wire palette_snoop_accept,
	output reg err_msg_q,
	output reg serr_out_q,
	output reg serr_oe_q,
	output reg intx_out_q,
	// Interrupt.
	output wire irq
);

	wire [1:0] strap_s;
	wire reverse_s = strap_s[0];
	wire pcix_s = strap_s[1];
	reg [15:0] cmd_q;
	reg mdpe_q;
	reg [`SCR_EV_W-1:0] ev_stat_q;
	reg [`SCR_EV_W-1:0] ev_mask_q;
	reg intx_gate_q;
	wire [15:0] wmask;
	wire [`SCR_EV_W-1:0] ev_set;
	wire parity_hit;
	wire blocked;

	scr_sync #(
		.W(2)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.async_in({pcix_mode_pin, reverse_mode_pin}),
		.sync_out(strap_s)
	);

	function hit;
		input [`SCR_ADDR_W-1:0] a;
		input [`SCR_ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// Writable bits; bit 10 depends on the bridge direction.
	assign wmask = `SCR_CMD_RW_MASK |
		(((reverse_s && INTX_DIS_RW_REV != 0) ||
		(!reverse_s && INTX_DIS_RW_FWD != 0)) ?
		16'h0400 : 16'h0000);

	// Command register.
	always @(posedge clk_sys) begin
		if (!resetn) begin
			cmd_q <= `SCR_CMD_RESET;
		end else if (reg_wr && hit(reg_addr, `SCR_OFF_CMD)) begin
			cmd_q <= reg_wdata[15:0] & wmask;
		end
	end

	// Gates on the secondary datapath.
	assign io_accept = io_req && cmd_q[`SCR_BIT_IO_EN] &&
		cmd_q[`SCR_BIT_BM_EN];
	assign mem_rd_accept = mem_rd_req && cmd_q[`SCR_BIT_MEM_EN] &&
		cmd_q[`SCR_BIT_BM_EN];
	assign mem_accept = mem_req && cmd_q[`SCR_BIT_BM_EN];
	assign master_grant = master_req && cmd_q[`SCR_BIT_BM_EN];
	// Split completions bypass the master enable only in reverse PCI-X.
	assign split_cpl_grant = split_cpl_req &&
		(cmd_q[`SCR_BIT_BM_EN] || (reverse_s && pcix_s));
	assign special_cycle_accept = 1'b0 & special_cycle_req;
	assign palette_snoop_accept = 1'b0 & palette_snoop_req;

	assign parity_hit = parity_err && cmd_q[`SCR_BIT_PERR_EN];
	assign blocked = (io_req && !io_accept) ||
		(mem_rd_req && !mem_rd_accept) || (master_req && !master_grant);

	// Master data parity error flag; a new error wins over the clear.
	always @(posedge clk_sys) begin
		if (!resetn) begin
			mdpe_q <= 1'b0;
		end else if (parity_hit) begin
			mdpe_q <= 1'b1;
		end else if (reg_wr && hit(reg_addr, `SCR_OFF_CMD) &&
			reg_wdata[`SCR_BIT_MDPE]) begin
			mdpe_q <= 1'b0;
		end
	end

	// System error reporting, per bridge direction.
	always @(posedge clk_sys) begin
		if (!resetn) begin
			err_msg_q <= 1'b0;
			serr_out_q <= 1'b0;
			serr_oe_q <= 1'b0;
		end else begin
			err_msg_q <= fatal_err && !reverse_s &&
				cmd_q[`SCR_BIT_SERR_EN];
			// Open-drain pin: drive low only while reporting.
			serr_out_q <= 1'b0;
			serr_oe_q <= fatal_err && reverse_s &&
				cmd_q[`SCR_BIT_SERR_EN];
		end
	end

	// INTx: disable drops any asserted level on the next clock.
	always @(posedge clk_sys) begin
		if (!resetn) begin
			intx_gate_q <= 1'b0;
			intx_out_q <= 1'b0;
		end else begin
			intx_gate_q <= !cmd_q[`SCR_BIT_INTX_DIS];
			intx_out_q <= intx_req && !cmd_q[`SCR_BIT_INTX_DIS];
		end
	end

	// Event status, sticky; set wins over write-one-to-clear.
	assign ev_set = {blocked, err_msg_q | serr_oe_q, parity_hit};
	always @(posedge clk_sys) begin
		if (!resetn) begin
			ev_stat_q <= `SCR_EV_RESET;
			ev_mask_q <= `SCR_EV_RESET;
		end else begin
			if (reg_wr && hit(reg_addr, `SCR_OFF_IRQ_STAT)) begin
				ev_stat_q <= (ev_stat_q & ~reg_wdata[`SCR_EV_W-1:0]) | ev_set;
			end else begin
				ev_stat_q <= ev_stat_q | ev_set;
			end
			if (reg_wr && hit(reg_addr, `SCR_OFF_IRQ_MASK)) begin
				ev_mask_q <= reg_wdata[`SCR_EV_W-1:0];
			end
		end
	end
	assign irq = |(ev_stat_q & ev_mask_q);

	// Read data, one cycle after the strobe.
	always @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
			`SCR_OFF_CMD: reg_rdata <= {7'h00, mdpe_q, 8'h00, cmd_q};
			`SCR_OFF_IRQ_STAT: reg_rdata <= {29'h0, ev_stat_q};
			`SCR_OFF_IRQ_MASK: reg_rdata <= {29'h0, ev_mask_q};
			`SCR_OFF_CTRL: reg_rdata <= {29'h0, intx_gate_q, pcix_s,
				reverse_s};
			default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule

// >>> bench/scr_checker.sv
/*
 Port checker for scr_cmd_reg.
 Assumes one clock and a synchronous active-low reset.
*/
module scr_checker (
	// Clock and reset.
	input wire clk_sys,
	input wire resetn,
	// Register port.
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Requests and gates.
	input wire io_req,
	input wire io_accept,
	input wire mem_req,
	input wire mem_accept,
	input wire master_req,
	input wire master_grant,
	input wire split_cpl_req,
	input wire split_cpl_grant,
	input wire special_cycle_accept,
	input wire fatal_err,
	input wire err_msg_q,
	input wire serr_oe_q,
	input wire intx_req,
	input wire intx_out_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence quiet_in;
		!fatal_err && !intx_req;
	endsequence
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	special_zero_a: assert property (special_cycle_accept == 1'b0)
		else $error("special cycle accepted");
	io_gate_a: assert property (io_accept |-> io_req && !(master_req && !master_grant))
		else $error("io accepted without enable");
	mem_gate_a: assert property (master_req && mem_req |-> mem_accept == master_grant)
		else $error("memory gate differs from master gate");
	split_gate_a: assert property (master_grant && split_cpl_req |-> split_cpl_grant)
		else $error("split completion refused");
	err_path_a: assert property (err_msg_q |-> $past(fatal_err) && !serr_oe_q)
		else $error("error message without cause");
	serr_cause_a: assert property ($rose(serr_oe_q) |-> $past(fatal_err))
		else $error("system error pin without cause");
	quiet_out_a: assert property (quiet_in |=> !err_msg_q && !serr_oe_q && !intx_out_q)
		else $error("output without request");
endmodule
bind scr_cmd_reg scr_checker chk (.*);

// >>> bench/scr_agent.sv
/*
 Secondary bus agent: turns the bench's wishes into held request levels.
 Assumes the bench changes its wishes away from the clock edge.
*/
module scr_agent (
	// Clock.
	input wire clk_sys,
	// Wishes and requests.
	input wire [9:0] want,
	output logic [9:0] req
);
	timeunit 1ns;
	timeprecision 1ps;
	// Requests change only after an edge, as a real agent's would.
	always @(posedge clk_sys) begin
		req <= want;
	end
endmodule

// >>> bench/scr_cmd_reg_bench.sv
/*
 Self-checking bench for scr_cmd_reg.
 Assumes the agent model and checker are compiled first.
*/
module scr_cmd_reg_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, rev = 0, pcix = 0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [9:0] want = 10'h0;
	wire [31:0] reg_rdata;
	wire [9:0] rq;
	wire io_a, mr_a, m_a, mg, sg, sc_a, ps_a, em, so, soe, ix, irq;
	int num_errors = 0, tests_run = 0;
	scr_agent agent (.clk_sys(clk_sys), .want(want), .req(rq));
	scr_cmd_reg dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reverse_mode_pin(rev), .pcix_mode_pin(pcix),
		.io_req(rq[0]), .mem_rd_req(rq[1]), .mem_req(rq[2]),
		.master_req(rq[3]), .split_cpl_req(rq[4]), .special_cycle_req(rq[5]),
		.palette_snoop_req(rq[6]), .parity_err(rq[7]), .fatal_err(rq[8]),
		.intx_req(rq[9]), .io_accept(io_a), .mem_rd_accept(mr_a),
		.mem_accept(m_a), .master_grant(mg), .split_cpl_grant(sg),
		.special_cycle_accept(sc_a), .palette_snoop_accept(ps_a),
		.err_msg_q(em), .serr_out_q(so), .serr_oe_q(soe), .intx_out_q(ix),
		.irq(irq));
	initial forever #20 clk_sys = ~clk_sys;
	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	task rd(logic [7:0] a, logic [31:0] e);
		@(posedge clk_sys);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 chk("rdata", e, reg_rdata);
	endtask
	// Three edges cover the agent register and the design's own flop.
	task req(logic [9:0] w);
		want <= w;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	function logic [31:0] gates;
		return 32'({io_a, mr_a, m_a, mg, sg, sc_a, ps_a});
	endfunction
	task t_on;
		rd(8'h44, 32'h0);
		rd(8'h10, 32'h0);
		wr(8'h44, 32'hFFFFFFFF);
		rd(8'h44, 32'h547);
		req(10'h07F);
		chk("gates", 32'h7C, gates());
		req(10'h300);
		chk("intx", 32'h0, 32'(ix));
		chk("errmsg", 32'h1, 32'(em));
		$display("test on done");
	endtask
	task t_parity;
		req(10'h080);
		req(10'h000);
		rd(8'h44, 32'h01000547);
		chk("irq", 32'h0, 32'(irq));
		wr(8'h84, 32'h1);
		#1 chk("irq", 32'h1, 32'(irq));
		wr(8'h80, 32'h7);
		#1 chk("irq", 32'h0, 32'(irq));
		wr(8'h44, 32'h01000547);
		rd(8'h44, 32'h547);
		$display("test parity done");
	endtask
	task t_off;
		wr(8'h44, 32'h0);
		req(10'h07F);
		chk("gates", 32'h0, gates());
		req(10'h380);
		chk("intx", 32'h1, 32'(ix));
		chk("errmsg", 32'h0, 32'(em));
		rd(8'h44, 32'h0);
		$display("test off done");
	endtask
	task t_rev;
		rev <= 1;
		pcix <= 1;
		req(10'h010);
		chk("split", 32'h1, 32'(sg));
		wr(8'h44, 32'h500);
		rd(8'h44, 32'h100);
		req(10'h100);
		chk("serr", 32'h4, 32'({soe, em, so}));
		$display("test reverse done");
	endtask
	initial begin
		#200us;
		num_errors++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1;
		repeat (3) @(posedge clk_sys);
		t_on();
		t_parity();
		t_off();
		t_rev();
		summarize();
	end
endmodule
